/* File: sim/sre_exec_chk.sv */
// Port checker of the stack and return executor
`timescale 1ns/1ps
module sre_exec_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic [7:0] op_code,
  input wire logic [2:0] op_mode,
  input wire logic [31:0] op_ea,
  input wire logic [31:0] op_value,
  input wire logic done,
  input wire logic illegal_operand,
  input wire logic pc_load,
  input wire logic [31:0] pc_value,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire take = op_valid && op_ready;
  wire pop_t = take && op_code == sre_pkg::OP_WORD_POP;
  wire pea_t = take && op_code == sre_pkg::OP_PUSH_EA;
  wire psh_t = take && op_code == sre_pkg::OP_WORD_PUSH;
  wire rs_t = take && op_code == sre_pkg::OP_RESTORE;
  wire exp_m = op_mode == sre_pkg::MODE_EXPANDED;
  wire bad_pop = pop_t && (exp_m || op_mode == sre_pkg::MODE_LITERAL ||
    op_mode == sre_pkg::MODE_IMMEDIATE);
  wire bad_pea = pea_t && op_mode < sre_pkg::MODE_MEMORY;

  a_pop_illegal: assert property (
    bad_pop |=> illegal_operand && done && !mem_req)
    else $error("pop illegal operand missing");
  a_pea_illegal: assert property (
    bad_pea |=> illegal_operand && done)
    else $error("push address illegal operand missing");
  a_push_illegal: assert property (
    psh_t && exp_m |=> illegal_operand && !mem_req)
    else $error("push illegal operand missing");
  a_push_legal: assert property (
    psh_t && !exp_m |=> !illegal_operand [*2])
    else $error("push legal mode refused");
  a_rs_illegal: assert property (
    rs_t && exp_m |=> illegal_operand && done)
    else $error("restore illegal operand missing");
  a_pop_read: assert property (
    pop_t && !bad_pop |=> mem_req && !mem_we)
    else $error("pop does not read stack");
  a_push_data: assert property (
    psh_t && !exp_m |=> mem_req && mem_we && mem_wdata == $past(op_value))
    else $error("push data wrong");
  a_pea_data: assert property (
    pea_t && !bad_pea |=> mem_req && mem_we && mem_wdata == $past(op_ea))
    else $error("push address data wrong");
  a_ret_pc: assert property (
    pc_load |-> done && $past(mem_ready) && pc_value == $past(mem_rdata))
    else $error("return program counter wrong");
  a_done_ready: assert property (
    done |-> op_ready && !mem_req)
    else $error("not ready after instruction end");

  c_ret: cover property (pc_load);
  c_illegal: cover property (illegal_operand);
  c_restore: cover property (rs_t && !exp_m ##[1:60] done);
endmodule

bind sre_exec sre_exec_chk u_chk (.mclk(mclk), .reset(reset),
  .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
  .op_mode(op_mode), .op_ea(op_ea), .op_value(op_value), .done(done),
  .illegal_operand(illegal_operand), .pc_load(pc_load),
  .pc_value(pc_value), .mem_req(mem_req), .mem_we(mem_we),
  .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rdata(mem_rdata));

/* File: sim/sre_mem_model.sv */
// Behavioural word memory answering the executor's stack accesses
`timescale 1ns/1ps
module sre_mem_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] wait_cycles,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ready,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:255];
  logic [1:0] cnt;

  // Read data stand only in the completing cycle, else they toggle
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      mem_ready <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 32'hA5A5A5A5;
    end else if (mem_ready) begin
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_we) begin
        mem[mem_addr[9:2]] <= mem_wdata;
      end
    end else if (mem_req && cnt >= wait_cycles) begin
      mem_ready <= 1'b1;
      cnt <= 2'h0;
      mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr[9:2]];
    end else begin
      cnt <= mem_req ? cnt + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

/* File: sim/tb.sv */
// Self-checking bench of the stack and return executor
`timescale 1ns/1ps
module tb;
  logic mclk, reset, op_valid, op_ready, done, illegal_operand, pc_load;
  logic [7:0] op_code, bus_addr;
  logic [2:0] op_mode;
  logic [3:0] op_reg;
  logic [31:0] op_ea, op_value, pc_value, mem_addr, mem_wdata, mem_rdata;
  logic mem_req, mem_we, mem_ready, bus_wr, bus_rd, irq, ill, pl;
  logic [31:0] bus_wdata, bus_rdata;
  logic [1:0] wait_cycles;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  // Opcode and mode pairs that must be refused
  logic [10:0] bad [9] = '{{8'h20, 3'h1}, {8'h20, 3'h2}, {8'h20, 3'h3},
    {8'hE0, 3'h0}, {8'hE0, 3'h1}, {8'hE0, 3'h2}, {8'hE0, 3'h3},
    {8'hA0, 3'h3}, {8'h18, 3'h3}};
  // Opcode, flags NZCV, return taken
  logic [12:0] rets [8] = '{{8'h50, 4'h0, 1'b1}, {8'h50, 4'h2, 1'b0},
    {8'h58, 4'h2, 1'b1}, {8'h58, 4'hD, 1'b0}, {8'h7C, 4'h4, 1'b1},
    {8'h7C, 4'hB, 1'b0}, {8'h6C, 4'h4, 1'b1}, {8'h6C, 4'h0, 1'b0}};

  sre_exec u_dut (.mclk, .reset, .op_valid, .op_ready, .op_code, .op_mode,
    .op_reg, .op_ea, .op_value, .done, .illegal_operand, .pc_load,
    .pc_value, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ready,
    .mem_rdata, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .irq);
  sre_mem_model u_mem (.mclk, .reset, .wait_cycles, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ready, .mem_rdata);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    @(negedge mclk);
    check32(bus_rdata, exp);
  endtask

  task automatic irq_chk(input logic e);
    @(negedge mclk);
    check32({31'h0, irq}, {31'h0, e});
  endtask

  task automatic run(input logic [7:0] c, input logic [2:0] m,
      input logic [3:0] r, input logic [31:0] ea, input logic [31:0] v);
    int n;
    @(posedge mclk);
    op_code <= c;
    op_mode <= m;
    op_reg <= r;
    op_ea <= ea;
    op_value <= v;
    op_valid <= 1'b1;
    @(posedge mclk);
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      ill = illegal_operand;
      pl = pc_load;
    end while (done !== 1'b1 && n < 60);
    if (n >= 60) num_errors++;
  endtask

  task automatic state(input logic [31:0] sp, input logic [31:0] fl);
    rd_chk(8'h04, sp);
    rd_chk(8'h00, fl);
  endtask

  initial begin
    {reset, op_valid, bus_wr, bus_rd} = 4'hF - 4'h7;
    {op_code, op_mode, op_reg, bus_addr} = '0;
    {op_ea, op_value, bus_wdata} = '0;
    wait_cycles = 2'h0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 24; i += 4) rd_chk(8'(i), 32'h0);
    rd_chk(8'h18, 32'h1);
    wr(8'h04, 32'h100);
    wr(8'h00, 32'hF);
    run(8'hA0, 3'h4, 4'h0, 32'h0, 32'h80000000);
    check32(u_mem.mem[64], 32'h80000000);
    state(32'h104, 32'h8);
    run(8'hA0, 3'h0, 4'h0, 32'h0, 32'h0);
    check32(u_mem.mem[65], 32'h0);
    state(32'h108, 32'h4);
    wr(8'h00, 32'hF);
    run(8'hE0, 3'h4, 4'h0, 32'h80000010, 32'h0);
    check32(u_mem.mem[66], 32'h80000010);
    state(32'h10C, 32'hC);
    wr(8'h00, 32'hF);
    run(8'h20, 3'h0, 4'h5, 32'h0, 32'h0);
    rd_chk(8'h54, 32'h80000010);
    state(32'h108, 32'h8);
    wait_cycles <= 2'h2;
    run(8'h20, 3'h4, 4'h0, 32'h200, 32'h0);
    check32(u_mem.mem[128], 32'h0);
    state(32'h104, 32'h4);
    foreach (bad[i]) begin
      run(bad[i][10:3], bad[i][2:0], 4'h3, 32'h200, 32'h1);
      check32({31'h0, ill}, 32'h1);
    end
    run(8'h70, 3'h0, 4'h0, 32'h0, 32'h0);
    check32({31'h0, pl}, 32'h0);
    state(32'h104, 32'h4);
    wait_cycles <= 2'h0;
    u_mem.mem[64] = 32'h444;
    foreach (rets[i]) begin
      wr(8'h0C, 32'hAB0);
      wr(8'h00, {28'h0, rets[i][4:1]});
      run(rets[i][12:5], 3'h0, 4'h0, 32'h0, 32'h0);
      check32({31'h0, pl}, {31'h0, rets[i][0]});
      rd_chk(8'h0C, rets[i][0] ? 32'h444 : 32'hAB0);
      state(32'h104, {28'h0, rets[i][4:1]});
    end
    wait_cycles <= 2'h1;
    wr(8'h08, 32'h300);
    wr(8'h48, 32'h55);
    wr(8'h64, 32'h99);
    wr(8'h00, 32'hA);
    u_mem.mem[185] = 32'h280;
    for (int i = 0; i < 6; i++) u_mem.mem[186 + i] = 32'(48 + i);
    run(8'h18, 3'h0, 4'h3, 32'h0, 32'h0);
    state(32'h2E4, 32'hA);
    rd_chk(8'h08, 32'h280);
    for (int i = 0; i < 6; i++) rd_chk(8'(76 + 4 * i), 32'(48 + i));
    rd_chk(8'h48, 32'h55);
    rd_chk(8'h64, 32'h99);
    rd_chk(8'h10, 32'h7);
    wr(8'h14, 32'h1);
    irq_chk(1'b1);
    wr(8'h10, 32'h1);
    irq_chk(1'b0);
    rd_chk(8'h10, 32'h6);
    wr(8'h14, 32'h6);
    irq_chk(1'b1);
    wr(8'h10, 32'h6);
    irq_chk(1'b0);
    rd_chk(8'h30, 32'h0);
    print_verdict();
  end
endmodule

/* File: src/sre_cond.sv */
// Conditional return decode and condition test
`timescale 1ns/1ps
module sre_cond (
  input wire logic [7:0] op_code,
  input wire logic [3:0] flags,
  output logic is_ret,
  output logic take
);
  always_comb begin
    is_ret = 1'b1;
    take = 1'b0;
    case (op_code)
      sre_pkg::OP_RET_CC: take = ~flags[sre_pkg::FLAG_C]; // RQ10
      sre_pkg::OP_RET_CS: take = flags[sre_pkg::FLAG_C]; // RQ11
      sre_pkg::OP_RET_EQ_S,
      sre_pkg::OP_RET_EQ_U: take = flags[sre_pkg::FLAG_Z]; // RQ12
      default: is_ret = 1'b0;
    endcase
  end
endmodule

/* File: src/sre_exec.sv */
// Stack, push, pop, conditional return and restore executor
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// RQ1 - Word pop stores the stack top word into the destination operand.
// RQ2 - Word pop with literal, expanded or immediate destination is illegal.
// RQ3 - Software never pops into the stack pointer; result undefined.
// RQ4 - Word pop sets N, Z from stored value, clears C and V.
// RQ5 - Push address stores operand effective address at top, advances SP.
// RQ6 - Push address: literal, register, expanded, immediate source illegal.
// RQ7 - Push address: N from address MSB, Z from source, C, V clear.
// RQ8 - Word push stores source, advances SP, sets N, Z, clears C, V.
// RQ9 - Word push with expanded source is illegal; other modes accepted.
// RQ10 - Return on carry clear loads PC from stack top when C is zero.
// RQ11 - Return on carry set loads PC from stack top when C is one.
// RQ12 - Both return on equal opcodes load PC when Z is one.
// RQ13 - Restore: SP = FP-28, FP = word at FP-28, registers from FP-24.
// RQ14 - Restore reloads registers from operand number up to register 8.
// RQ15 - Software gives restore a register operand numbered 0 through 9.
// RQ16 - Restore with expanded operand is illegal; flags always unchanged.
// RQ17 - Stack grows upward; push writes at SP then adds four.
module sre_exec (
  input wire logic mclk,
  input wire logic reset,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [7:0] op_code,
  input wire logic [2:0] op_mode,
  input wire logic [3:0] op_reg,
  input wire logic [31:0] op_ea,
  input wire logic [31:0] op_value,
  output logic done,
  output logic illegal_operand,
  output logic pc_load,
  output logic [31:0] pc_value,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic irq
);
  sre_pkg::sre_st_s s;
  sre_pkg::sre_st_s next_s;
  logic is_ret;
  logic take;
  logic [sre_pkg::EV_W-1:0] ev;
  logic [sre_pkg::EV_W-1:0] clr;

  sre_rf_if rf ();

  sre_regfile #(
    .DEPTH(16)
  ) u_rf (
    .mclk(mclk),
    .rf(rf)
  );

  sre_cond u_cond (
    .op_code(op_code),
    .flags(s.flags),
    .is_ret(is_ret),
    .take(take)
  );

  // Flag word for a stored word: N from value, Z from the zero input, C and V clear
  function automatic logic [3:0] nz_flags(input logic [31:0] val,
    input logic zero);
    logic [3:0] f;
    f = 4'h0;
    f[sre_pkg::FLAG_N] = val[31];
    f[sre_pkg::FLAG_Z] = zero;
    return f;
  endfunction

  function automatic logic bad_pop_mode(input logic [2:0] m);
    return m == sre_pkg::MODE_LITERAL || m == sre_pkg::MODE_EXPANDED ||
      m == sre_pkg::MODE_IMMEDIATE;
  endfunction

  function automatic logic bad_pushea_mode(input logic [2:0] m);
    return m == sre_pkg::MODE_LITERAL || m == sre_pkg::MODE_REGISTER ||
      m == sre_pkg::MODE_EXPANDED || m == sre_pkg::MODE_IMMEDIATE;
  endfunction

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.illegal = 1'b0;
    next_s.pc_load = 1'b0;
    ev = '0;
    clr = '0;
    rf.we = 1'b0;
    rf.waddr = s.rs_n;
    rf.wdata = mem_rdata;
    rf.raddr = bus_addr[5:2];

    case (s.state)
      sre_pkg::ST_IDLE: begin
        if (op_valid) begin
          next_s.dmode = op_mode;
          next_s.dreg = op_reg;
          next_s.dea = op_ea;
          case (op_code)
            sre_pkg::OP_WORD_POP: begin
              if (bad_pop_mode(op_mode)) begin // RQ2
                next_s.illegal = 1'b1;
              end else begin
                // Top word sits just below SP on an upward stack
                next_s.mem_addr = s.sp - sre_pkg::WORD_BYTES; // RQ1
                next_s.state = sre_pkg::ST_POP_RD;
              end
            end
            sre_pkg::OP_PUSH_EA: begin
              if (bad_pushea_mode(op_mode)) begin // RQ6
                next_s.illegal = 1'b1;
              end else begin
                next_s.mem_addr = s.sp; // RQ17
                next_s.mem_wdata = op_ea; // RQ5
                next_s.pend_flags = nz_flags(op_ea,
                  op_value == 32'h00000000); // RQ7
                next_s.state = sre_pkg::ST_PUSH_WR;
              end
            end
            sre_pkg::OP_WORD_PUSH: begin
              if (op_mode == sre_pkg::MODE_EXPANDED) begin // RQ9
                next_s.illegal = 1'b1;
              end else begin
                next_s.mem_addr = s.sp; // RQ17
                next_s.mem_wdata = op_value; // RQ8
                next_s.pend_flags = nz_flags(op_value,
                  op_value == 32'h00000000); // RQ8
                next_s.state = sre_pkg::ST_PUSH_WR;
              end
            end
            sre_pkg::OP_RESTORE: begin
              if (op_mode == sre_pkg::MODE_EXPANDED) begin // RQ16
                next_s.illegal = 1'b1;
              end else begin
                next_s.mem_addr = s.fp - sre_pkg::FRAME_SP_OFS; // RQ13
                next_s.rs_n = op_reg; // RQ14
                next_s.state = sre_pkg::ST_RS_FP;
              end
            end
            default: begin
              if (is_ret && take) begin // RQ10 RQ11 RQ12
                next_s.mem_addr = s.sp - sre_pkg::WORD_BYTES;
                next_s.state = sre_pkg::ST_RET_RD;
              end else begin
                // False condition or foreign opcode: fall through
                next_s.done = 1'b1; // RQ10 RQ11 RQ12
                ev[sre_pkg::EV_DONE] = 1'b1;
              end
            end
          endcase
          if (next_s.illegal) begin
            next_s.done = 1'b1;
            ev[sre_pkg::EV_ILLEGAL] = 1'b1;
            ev[sre_pkg::EV_DONE] = 1'b1;
          end
        end
      end
      sre_pkg::ST_POP_RD: begin
        if (mem_ready) begin
          next_s.sp = s.sp - sre_pkg::WORD_BYTES;
          next_s.flags = nz_flags(mem_rdata,
            mem_rdata == 32'h00000000); // RQ4
          if (s.dmode == sre_pkg::MODE_REGISTER) begin
            rf.we = 1'b1; // RQ1
            rf.waddr = s.dreg;
            next_s.done = 1'b1;
            ev[sre_pkg::EV_DONE] = 1'b1;
            next_s.state = sre_pkg::ST_IDLE;
          end else begin
            next_s.mem_addr = s.dea; // RQ1
            next_s.mem_wdata = mem_rdata;
            next_s.state = sre_pkg::ST_POP_WR;
          end
        end
      end
      sre_pkg::ST_POP_WR: begin
        if (mem_ready) begin
          next_s.done = 1'b1;
          ev[sre_pkg::EV_DONE] = 1'b1;
          next_s.state = sre_pkg::ST_IDLE;
        end
      end
      sre_pkg::ST_PUSH_WR: begin
        if (mem_ready) begin
          next_s.sp = s.sp + sre_pkg::WORD_BYTES; // RQ17
          next_s.flags = s.pend_flags; // RQ7
          next_s.done = 1'b1;
          ev[sre_pkg::EV_DONE] = 1'b1;
          next_s.state = sre_pkg::ST_IDLE;
        end
      end
      sre_pkg::ST_RET_RD: begin
        if (mem_ready) begin
          next_s.pc = mem_rdata; // RQ10
          next_s.pc_load = 1'b1;
          next_s.done = 1'b1;
          ev[sre_pkg::EV_RETURN] = 1'b1;
          ev[sre_pkg::EV_DONE] = 1'b1;
          next_s.state = sre_pkg::ST_IDLE;
        end
      end
      sre_pkg::ST_RS_FP: begin
        if (mem_ready) begin
          next_s.new_fp = mem_rdata; // RQ13
          next_s.mem_addr = s.fp - sre_pkg::FRAME_REG_OFS; // RQ13
          if (s.rs_n <= sre_pkg::RS_LAST_REG) begin
            next_s.state = sre_pkg::ST_RS_REG;
          end else begin
            next_s.state = sre_pkg::ST_FINISH;
          end
        end
      end
      sre_pkg::ST_RS_REG: begin
        if (mem_ready) begin
          rf.we = 1'b1; // RQ14
          next_s.rs_n = s.rs_n + 4'h1;
          next_s.mem_addr = s.mem_addr + sre_pkg::WORD_BYTES;
          if (s.rs_n == sre_pkg::RS_LAST_REG) begin // RQ14
            next_s.state = sre_pkg::ST_FINISH;
          end
        end
      end
      sre_pkg::ST_FINISH: begin
        // SP and FP move together once the frame is read
        next_s.sp = s.fp - sre_pkg::FRAME_SP_OFS; // RQ13
        next_s.fp = s.new_fp; // RQ13
        next_s.done = 1'b1;
        ev[sre_pkg::EV_DONE] = 1'b1;
        next_s.state = sre_pkg::ST_IDLE;
      end
      default: begin
        // Stray state code: back to idle
        next_s.state = sre_pkg::ST_IDLE;
      end
    endcase

    // Register writes; core registers only while idle
    if (bus_wr) begin
      if (bus_addr == sre_pkg::ADDR_STATUS) begin
        clr = bus_wdata[sre_pkg::EV_W-1:0];
      end else if (bus_addr == sre_pkg::ADDR_MASK) begin
        next_s.mask = bus_wdata[sre_pkg::EV_W-1:0];
      end else if (s.state == sre_pkg::ST_IDLE && !op_valid) begin
        if (bus_addr == sre_pkg::ADDR_FLAGS) begin
          next_s.flags = bus_wdata[3:0];
        end else if (bus_addr == sre_pkg::ADDR_SP) begin
          next_s.sp = bus_wdata;
        end else if (bus_addr == sre_pkg::ADDR_FP) begin
          next_s.fp = bus_wdata;
        end else if (bus_addr == sre_pkg::ADDR_PC) begin
          next_s.pc = bus_wdata;
        end else if ((bus_addr & sre_pkg::ADDR_GPR_MASK) ==
          sre_pkg::ADDR_GPR_BASE) begin
          rf.we = 1'b1;
          rf.waddr = bus_addr[5:2];
          rf.wdata = bus_wdata;
        end
      end
    end
    // Hardware set wins over a same-cycle clear
    next_s.status = (s.status & ~clr) | ev;

    // Read data: local registers captured here, GPR from the file
    next_s.rd_gpr = 1'b0;
    next_s.rdata_local = 32'h00000000;
    if (bus_rd) begin
      if ((bus_addr & sre_pkg::ADDR_GPR_MASK) ==
        sre_pkg::ADDR_GPR_BASE) begin
        next_s.rd_gpr = 1'b1;
      end else begin
        case (bus_addr)
          sre_pkg::ADDR_FLAGS: next_s.rdata_local = {28'h0, s.flags};
          sre_pkg::ADDR_SP: next_s.rdata_local = s.sp;
          sre_pkg::ADDR_FP: next_s.rdata_local = s.fp;
          sre_pkg::ADDR_PC: next_s.rdata_local = s.pc;
          sre_pkg::ADDR_STATUS: next_s.rdata_local = {29'h0, s.status};
          sre_pkg::ADDR_MASK: next_s.rdata_local = {29'h0, s.mask};
          sre_pkg::ADDR_STATE: next_s.rdata_local = {24'h0, s.state};
          default: next_s.rdata_local = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.state <= sre_pkg::ST_IDLE;
      s.sp <= sre_pkg::SP_RST;
      s.fp <= sre_pkg::FP_RST;
      s.pc <= sre_pkg::PC_RST;
      s.flags <= sre_pkg::FLAGS_RST;
      s.mask <= sre_pkg::MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // Ready and memory strobes decoded from the state alone
  always_comb begin
    op_ready = 1'b0;
    mem_req = 1'b0;
    mem_we = 1'b0;
    case (s.state)
      sre_pkg::ST_IDLE: begin
        op_ready = 1'b1;
      end
      sre_pkg::ST_POP_RD,
      sre_pkg::ST_RET_RD,
      sre_pkg::ST_RS_FP,
      sre_pkg::ST_RS_REG: begin
        mem_req = 1'b1;
      end
      sre_pkg::ST_POP_WR,
      sre_pkg::ST_PUSH_WR: begin
        mem_req = 1'b1;
        mem_we = 1'b1;
      end
      default: begin
        op_ready = 1'b0;
      end
    endcase
  end

  assign done = s.done;
  assign illegal_operand = s.illegal;
  assign pc_load = s.pc_load;
  assign pc_value = s.pc;
  assign mem_addr = s.mem_addr;
  assign mem_wdata = s.mem_wdata;
  assign bus_rdata = s.rd_gpr ? rf.rdata : s.rdata_local;
  assign irq = |(s.status & s.mask);
endmodule

/* File: src/sre_pkg.sv */
// Constants, state codes and state record of the stack and return executor
package sre_pkg;
  // Opcodes handled by this block
  localparam logic [7:0] OP_WORD_POP = 8'h20;
  localparam logic [7:0] OP_PUSH_EA = 8'hE0;
  localparam logic [7:0] OP_WORD_PUSH = 8'hA0;
  localparam logic [7:0] OP_RET_CC = 8'h50;
  localparam logic [7:0] OP_RET_CS = 8'h58;
  localparam logic [7:0] OP_RET_EQ_S = 8'h7C;
  localparam logic [7:0] OP_RET_EQ_U = 8'h6C;
  localparam logic [7:0] OP_RESTORE = 8'h18;
  // Operand addressing mode codes from the operand decoder
  localparam logic [2:0] MODE_REGISTER = 3'h0;
  localparam logic [2:0] MODE_LITERAL = 3'h1;
  localparam logic [2:0] MODE_IMMEDIATE = 3'h2;
  localparam logic [2:0] MODE_EXPANDED = 3'h3;
  localparam logic [2:0] MODE_MEMORY = 3'h4;
  // Stack and frame geometry
  localparam logic [31:0] WORD_BYTES = 32'h00000004;
  localparam logic [31:0] FRAME_SP_OFS = 32'h0000001C;
  localparam logic [31:0] FRAME_REG_OFS = 32'h00000018;
  localparam logic [3:0] RS_LAST_REG = 4'h8;
  // Flag positions in the flag word
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;
  // Register map, byte addresses
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_SP = 8'h04;
  localparam logic [7:0] ADDR_FP = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;
  localparam logic [7:0] ADDR_GPR_BASE = 8'h40;
  localparam logic [7:0] ADDR_GPR_MASK = 8'hC0;
  // Event bits of status and mask
  localparam int EV_ILLEGAL = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_DONE = 2;
  localparam int EV_W = 3;
  // Reset values
  localparam logic [31:0] SP_RST = 32'h00000000;
  localparam logic [31:0] FP_RST = 32'h00000000;
  localparam logic [31:0] PC_RST = 32'h00000000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_POP_RD = 8'h02,
    ST_POP_WR = 8'h04,
    ST_PUSH_WR = 8'h08,
    ST_RET_RD = 8'h10,
    ST_RS_FP = 8'h20,
    ST_RS_REG = 8'h40,
    ST_FINISH = 8'h80
  } sre_state_e;

  typedef struct packed {
    sre_state_e state;
    logic [31:0] sp;
    logic [31:0] fp;
    logic [31:0] pc;
    logic [3:0] flags;
    logic [3:0] pend_flags;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic done;
    logic illegal;
    logic pc_load;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [2:0] dmode;
    logic [3:0] dreg;
    logic [31:0] dea;
    logic [3:0] rs_n;
    logic [31:0] new_fp;
    logic rd_gpr;
    logic [31:0] rdata_local;
  } sre_st_s;
endpackage

/* File: src/sre_regfile.sv */
// General register file with registered read data
`timescale 1ns/1ps
module sre_regfile #(
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  sre_rf_if.store rf
);
  logic [31:0] mem [DEPTH];
  logic [31:0] rdata_q;

  always_ff @(posedge mclk) begin
    if (rf.we) begin
      mem[rf.waddr] <= rf.wdata;
    end
    rdata_q <= mem[rf.raddr];
  end

  assign rf.rdata = rdata_q;
endmodule

/* File: src/sre_rf_if.sv */
// Port bundle between the executor and its register file
`timescale 1ns/1ps
interface sre_rf_if;
  logic we;
  logic [3:0] waddr;
  logic [31:0] wdata;
  logic [3:0] raddr;
  logic [31:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr,
    input rdata);
  modport store (input we, input waddr, input wdata, input raddr,
    output rdata);
endinterface
